// *** verilog/pwmbrk_top.sv ***
// Brake logic and prescaler for a four-output PWM generator, with APB registers.
// Assumes the PWM engine outputs arrive on pwm_in and are gated here.
`timescale 1ns/1ns

// Behaviour
// - With the master enable clear no brake ever reaches the outputs.
// - The polarity bit picks a low (0) or high (1) pin level as the brake request.
// - During a brake each output takes its own brake level bit, bits 0 to 3 for outputs 0 to 3.
// - Enabled with pin-enable and stop-select both clear, the brake is held on by software.
// - Enabled with stop-select set and pin-enable clear, the outputs brake while the run bit is clear; with both set there is no brake.
// - Enabled with pin-enable set and stop-select clear, an active pin brakes the outputs, clears run and sets the flag.
// - The pin brake sets the sticky flag and only a software write clears it.
// - The prescale field selects system clock, /2, /4 or /16 and resets to 00.
// - The prescaled clock is phase aligned with the system clock while run is set.
// - When the brake cause goes away each output returns to its pre-brake state.
// - Software can poll the flag or use the brake event output to see a pin brake.
module pwmbrk_top (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Brake pin and PWM path
	input wire logic brake_pin,
	input wire logic [3:0] pwm_in,
	output logic [3:0] pwm_out,
	// Engine side
	output logic generator_run,
	output logic pwm_tick,
	output logic brake_active,
	output logic brake_event
);
	// ***************************
	// Registers
	// ***************************
	logic [7:0] brake_ctrl_r;
	logic [7:0] brake_ctrl_nxt;
	logic [1:0] prescale_r;
	logic [1:0] prescale_nxt;
	logic flag_r;
	logic flag_nxt;
	logic run_r;
	logic run_nxt;
	logic [1:0] sync_r;
	logic [1:0] sync_nxt;
	logic [3:0] out_r;
	logic [3:0] out_nxt;
	logic [3:0] hold_r;
	logic [3:0] hold_nxt;
	logic braked_r;
	logic braked_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;

	logic [9:0] word_idx;
	logic wr_en;
	logic rd_en;
	logic hit;
	logic pin_req;
	logic pin_brake;
	logic brake_now;
	pwmbrk_pkg::pwmbrk_mode_t mode;

	assign word_idx = paddr[11:2];
	assign wr_en = psel && penable && pwrite;
	// Read word is loaded in the setup cycle so it stands through the access edge
	assign rd_en = psel && !penable && !pwrite;
	assign hit = (word_idx == {2'h0, pwmbrk_pkg::PWMBRK_IDX_FREQ_FLAG})
		|| (word_idx == {2'h0, pwmbrk_pkg::PWMBRK_IDX_BRAKE_CTRL})
		|| (word_idx == {2'h0, pwmbrk_pkg::PWMBRK_IDX_GEN_CTRL})
		|| (word_idx == {2'h0, pwmbrk_pkg::PWMBRK_IDX_STATUS});
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = prdata_r;

	// ***************************
	// Brake decode
	// ***************************
	always_comb begin
		// Pin level after synchroniser, polarity applied
		pin_req = brake_ctrl_r[pwmbrk_pkg::PWMBRK_BC_POL] ? sync_r[1] : !sync_r[1];
		if (!brake_ctrl_r[pwmbrk_pkg::PWMBRK_BC_MASTER]) begin
			mode = pwmbrk_pkg::PWMBRK_M_OFF;
		end else begin
			case ({brake_ctrl_r[pwmbrk_pkg::PWMBRK_BC_PIN_EN], brake_ctrl_r[pwmbrk_pkg::PWMBRK_BC_STOP_SEL]})
				2'h0: mode = pwmbrk_pkg::PWMBRK_M_SOFT;
				2'h1: mode = pwmbrk_pkg::PWMBRK_M_STOP;
				2'h2: mode = pwmbrk_pkg::PWMBRK_M_PIN;
				default: mode = pwmbrk_pkg::PWMBRK_M_OFF;
			endcase
		end
		pin_brake = 1'b0;
		case (mode)
			pwmbrk_pkg::PWMBRK_M_OFF: brake_now = 1'b0;
			pwmbrk_pkg::PWMBRK_M_SOFT: brake_now = 1'b1;
			pwmbrk_pkg::PWMBRK_M_STOP: brake_now = !run_r;
			pwmbrk_pkg::PWMBRK_M_PIN: begin
				pin_brake = pin_req;
				brake_now = pin_req;
			end
			default: brake_now = 1'b0;
		endcase
	end

	// ***************************
	// Next state
	// ***************************
	always_comb begin
		brake_ctrl_nxt = brake_ctrl_r;
		prescale_nxt = prescale_r;
		flag_nxt = flag_r;
		run_nxt = run_r;
		sync_nxt = {sync_r[0], brake_pin};
		if (wr_en && word_idx == {2'h0, pwmbrk_pkg::PWMBRK_IDX_BRAKE_CTRL}) begin
			brake_ctrl_nxt = pwdata[7:0];
		end
		if (wr_en && word_idx == {2'h0, pwmbrk_pkg::PWMBRK_IDX_FREQ_FLAG}) begin
			prescale_nxt = pwdata[pwmbrk_pkg::PWMBRK_FF_PS_HI:pwmbrk_pkg::PWMBRK_FF_PS_LO];
			flag_nxt = pwdata[pwmbrk_pkg::PWMBRK_FF_FLAG];
		end
		if (wr_en && word_idx == {2'h0, pwmbrk_pkg::PWMBRK_IDX_GEN_CTRL}) begin
			run_nxt = pwdata[pwmbrk_pkg::PWMBRK_GC_RUN];
		end
		// Hardware set wins over a same-cycle software write
		if (pin_brake) begin
			flag_nxt = 1'b1;
			run_nxt = 1'b0;
		end
		// The hold copy freezes at the last pwm_in on brake entry, so release restores it
		hold_nxt = braked_r ? hold_r : pwm_in;
		braked_nxt = brake_now;
		if (brake_now) begin
			out_nxt = brake_ctrl_r[3:0];
		end else if (braked_r) begin
			out_nxt = hold_r;
		end else begin
			out_nxt = pwm_in;
		end
		prdata_nxt = 32'h0;
		if (rd_en) begin
			if (word_idx == {2'h0, pwmbrk_pkg::PWMBRK_IDX_BRAKE_CTRL}) begin
				prdata_nxt = {24'h0, brake_ctrl_r};
			end else if (word_idx == {2'h0, pwmbrk_pkg::PWMBRK_IDX_FREQ_FLAG}) begin
				prdata_nxt = {28'h0, prescale_r, 1'b0, flag_r};
			end else if (word_idx == {2'h0, pwmbrk_pkg::PWMBRK_IDX_GEN_CTRL}) begin
				prdata_nxt = {24'h0, run_r, 7'h0};
			end else if (word_idx == {2'h0, pwmbrk_pkg::PWMBRK_IDX_STATUS}) begin
				prdata_nxt = {24'h0, out_r, 2'h0, pin_req, braked_r};
			end
		end
	end

	// Read data is registered at the setup edge and cleared after the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brake_ctrl_r <= pwmbrk_pkg::PWMBRK_RST_BYTE;
			prescale_r <= pwmbrk_pkg::PWMBRK_PS_RST;
			flag_r <= 1'b0;
			run_r <= 1'b0;
			sync_r <= 2'h0;
			out_r <= 4'h0;
			hold_r <= 4'h0;
			braked_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			brake_ctrl_r <= brake_ctrl_nxt;
			prescale_r <= prescale_nxt;
			flag_r <= flag_nxt;
			run_r <= run_nxt;
			sync_r <= sync_nxt;
			out_r <= out_nxt;
			hold_r <= hold_nxt;
			braked_r <= braked_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// ***************************
	// Prescaler and outputs
	// ***************************
	pwmbrk_prescaler u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.run(run_r),
		.sel(prescale_r),
		.tick(pwm_tick)
	);

	assign pwm_out = out_r;
	assign generator_run = run_r;
	assign brake_active = braked_r;
	assign brake_event = pin_brake && !flag_r;
endmodule : pwmbrk_top

// *** verilog/pwmbrk_pkg.sv ***
// Package for the PWM brake and prescaler block.
// Holds register indices, field positions, reset values and state codes.
package pwmbrk_pkg;
	// ***************************
	// Register map (printed offsets are indices)
	// ***************************
	localparam logic [7:0] PWMBRK_IDX_FREQ_FLAG = 8'hD7;
	localparam logic [7:0] PWMBRK_IDX_BRAKE_CTRL = 8'hDF;
	localparam logic [7:0] PWMBRK_IDX_GEN_CTRL = 8'hE0;
	localparam logic [7:0] PWMBRK_IDX_STATUS = 8'hE1;
	localparam logic [7:0] PWMBRK_RST_BYTE = 8'h00;

	// ***************************
	// Brake control fields
	// ***************************
	localparam int PWMBRK_BC_STOP_SEL = 7;
	localparam int PWMBRK_BC_POL = 6;
	localparam int PWMBRK_BC_PIN_EN = 5;
	localparam int PWMBRK_BC_MASTER = 4;

	// ***************************
	// Frequency and flag fields
	// ***************************
	localparam int PWMBRK_FF_PS_HI = 3;
	localparam int PWMBRK_FF_PS_LO = 2;
	localparam int PWMBRK_FF_FLAG = 0;
	localparam int PWMBRK_GC_RUN = 7;
	localparam logic [1:0] PWMBRK_PS_RST = 2'h0;

	// ***************************
	// Prescaler divide terminal counts
	// ***************************
	localparam logic [3:0] PWMBRK_TC_DIV2 = 4'h1;
	localparam logic [3:0] PWMBRK_TC_DIV4 = 4'h3;
	localparam logic [3:0] PWMBRK_TC_DIV16 = 4'hF;

	typedef enum logic [1:0] {
		PWMBRK_PS_DIV1 = 2'h0,
		PWMBRK_PS_DIV2 = 2'h1,
		PWMBRK_PS_DIV4 = 2'h2,
		PWMBRK_PS_DIV16 = 2'h3
	} pwmbrk_ps_t;

	// Brake source mode, one-hot
	typedef enum logic [3:0] {
		PWMBRK_M_OFF = 4'h1,
		PWMBRK_M_SOFT = 4'h2,
		PWMBRK_M_STOP = 4'h4,
		PWMBRK_M_PIN = 4'h8
	} pwmbrk_mode_t;
endpackage : pwmbrk_pkg

// *** verilog/pwmbrk_prescaler.sv ***
// Prescaler that makes the PWM clock enable from the system clock.
// Assumes one clock; the enable is a one-cycle pulse, except at divide 1, where it stays high every cycle.
`timescale 1ns/1ns
module pwmbrk_prescaler (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic run,
	input wire logic [1:0] sel,
	// Output
	output logic tick
);
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic [3:0] tc;

	always_comb begin
		case (pwmbrk_pkg::pwmbrk_ps_t'(sel))
			pwmbrk_pkg::PWMBRK_PS_DIV2: tc = pwmbrk_pkg::PWMBRK_TC_DIV2;
			pwmbrk_pkg::PWMBRK_PS_DIV4: tc = pwmbrk_pkg::PWMBRK_TC_DIV4;
			pwmbrk_pkg::PWMBRK_PS_DIV16: tc = pwmbrk_pkg::PWMBRK_TC_DIV16;
			default: tc = 4'h0;
		endcase
		// Held at zero while stopped so the first tick lines up with run
		if (!run) begin
			cnt_nxt = 4'h0;
		end else if (cnt_r >= tc) begin
			cnt_nxt = 4'h0;
		end else begin
			cnt_nxt = cnt_r + 4'h1;
		end
		tick = run && (cnt_r >= tc);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule : pwmbrk_prescaler

// *** verif/pwmbrk_monitor.sv ***
// Checker for the brake and prescaler block, watching the top ports.
// Assumes it is bound to pwmbrk_top; register state is shadowed from APB writes.
`timescale 1ns/1ns
module pwmbrk_monitor (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// Outputs
	input wire logic [3:0] pwm_out,
	input wire logic generator_run,
	input wire logic pwm_tick,
	input wire logic brake_active,
	input wire logic brake_event
);
	logic wr;
	logic [7:0] bc_r, bc_nxt;
	logic [1:0] ps_r, ps_nxt;
	always_comb begin
		wr = psel && penable && pwrite && pready;
		bc_nxt = (wr && paddr == 12'h37C) ? pwdata[7:0] : bc_r;
		ps_nxt = (wr && paddr == 12'h35C) ? pwdata[3:2] : ps_r;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bc_r <= 8'h00;
			ps_r <= 2'h0;
		end else begin
			bc_r <= bc_nxt;
			ps_r <= ps_nxt;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_master_off: assert property (!$past(bc_r[4]) |-> !brake_active)
		else $error("brake while master enable clear");
	a_level_drive: assert property (brake_active |-> pwm_out == $past(bc_r[3:0]))
		else $error("outputs not at brake levels");
	a_soft_hold: assert property ($past(bc_r[7:4]) == 4'h1 |-> brake_active)
		else $error("software brake not held");
	a_stop_brake: assert property ($past(bc_r[7:4]) == 4'h9 |-> brake_active == !$past(generator_run))
		else $error("stop brake does not follow run");
	a_pin_event: assert property (brake_event |=> !generator_run && brake_active)
		else $error("pin brake left run set");
	a_combo_none: assert property ($past(bc_r[7] && bc_r[5]) |-> !brake_active)
		else $error("brake with both mode bits set");
	a_event_once: assert property (brake_event |=> !brake_event)
		else $error("flag event repeated");
	a_tick_div1: assert property (generator_run && $past(generator_run) && ps_r == 2'h0 && $past(ps_r) == 2'h0
		|-> pwm_tick)
		else $error("undivided tick missing");
	a_tick_div16: assert property (pwm_tick && ps_r == 2'h3 |=> !pwm_tick [*8])
		else $error("divide by sixteen tick too early");
endmodule : pwmbrk_monitor

// *** verif/pwmbrk_pin_model.sv ***
// Far side: brake pin source and PWM engine outputs.
// Assumes the bench requests the pin as active or idle and sets the engine pattern.
`timescale 1ns/1ns
module pwmbrk_pin_model (
	// Requests
	input wire logic req,
	input wire logic pol,
	input wire logic [3:0] pat,
	// Pins
	output logic brake_pin,
	output logic [3:0] pwm_in
);
	// Idle pin sits at the inverse of the active level
	assign brake_pin = req ? pol : !pol;
	assign pwm_in = pat;
endmodule : pwmbrk_pin_model

// *** verif/testbench.sv ***
// Self-checking bench for the PWM brake and prescaler block.
// Assumes APB read data standing at the access edge; outputs settle two edges later.
`timescale 1ns/1ns
module testbench;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, brake_pin, req = 1'b0, pol = 1'b0, err;
	logic [3:0] pat = 4'h0, pwm_in, pwm_out;
	logic generator_run, pwm_tick, brake_active, brake_event;
	int num_errors = 0, checks_done = 0, n;
	int sh[4] = '{0, 1, 2, 4};
	always #4 pclk = ~pclk;
	pwmbrk_top dut_u (.*);
	pwmbrk_pin_model pin_u (.*);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		err = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		// Two idle edges: registered outputs lag the stored write by one cycle
		repeat (2) @(posedge pclk);
	endtask : apb
	task automatic t_reset;
		apb(1'b0, 12'h35C, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 12'h004, 32'hFF);
		chk(32'(err), 32'h1);
		apb(1'b0, 12'h37C, 32'h0);
		chk(rd, 32'h0);
	endtask : t_reset
	task automatic t_soft;
		pat <= 4'h5;
		req <= 1'b1;
		apb(1'b1, 12'h37C, 32'h0F);
		chk(32'(pwm_out), 32'h5);
		pat <= 4'hA;
		apb(1'b1, 12'h37C, 32'h15);
		chk(32'(pwm_out), 32'h5);
		apb(1'b1, 12'h37C, 32'h0);
		chk(32'(pwm_out), 32'hA);
	endtask : t_soft
	task automatic t_stop;
		apb(1'b1, 12'h380, 32'h80);
		apb(1'b1, 12'h37C, 32'h93);
		chk(32'(pwm_out), 32'hA);
		apb(1'b1, 12'h380, 32'h0);
		chk(32'(pwm_out), 32'h3);
	endtask : t_stop
	task automatic t_pin(input logic p);
		pol <= p;
		req <= 1'b0;
		apb(1'b1, 12'h380, 32'h80);
		apb(1'b1, 12'h35C, 32'h0);
		apb(1'b1, 12'h37C, {24'h0, 1'b0, p, 6'h36});
		chk(32'(brake_active), 32'h0);
		req <= 1'b1;
		repeat (5) @(posedge pclk);
		chk(32'(pwm_out), 32'h6);
		apb(1'b0, 12'h380, 32'h0);
		chk(rd, 32'h0);
		req <= 1'b0;
		apb(1'b0, 12'h35C, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, 12'h35C, 32'h0);
		apb(1'b0, 12'h35C, 32'h0);
		chk(rd, 32'h0);
	endtask : t_pin
	task automatic t_combo;
		apb(1'b1, 12'h37C, 32'hB0);
		req <= 1'b1;
		repeat (5) @(posedge pclk);
		chk(32'(brake_active), 32'h0);
		req <= 1'b0;
	endtask : t_combo
	task automatic t_ps;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h35C, 32'(i << 2));
			apb(1'b1, 12'h380, 32'h80);
			n = 0;
			repeat (32) begin
				@(posedge pclk);
				n += int'(pwm_tick);
			end
			chk(32'(n), 32'(32 >> sh[i]));
			apb(1'b1, 12'h380, 32'h0);
		end
	endtask : t_ps
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	// Roughly six thousand cycles, far beyond the planned sequence
	initial begin
		#50000;
		num_errors++;
		wrap_up;
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_soft;
		t_stop;
		t_pin(1'b0);
		t_pin(1'b1);
		t_combo;
		t_ps;
		wrap_up;
	end
endmodule : testbench
bind pwmbrk_top pwmbrk_monitor mon_u (.*);
